// ### logic/wdg_pkg.sv
// wdg_pkg: constants, encodings and carrier types of the watchdog core.
// assumes nothing beyond a SystemVerilog compiler; shared by every watchdog file but the oscillator model.
package wdg_pkg;

    // counter geometry: three reload bytes form one down-counter
    localparam int COUNT_W        = 24;
    localparam int BYTE_W         = 8;

    // reload bytes after reset, upper / high / low
    localparam logic [7:0]  RELOAD_UPPER_RST = 8'h00;
    localparam logic [7:0]  RELOAD_HIGH_RST  = 8'h04;
    localparam logic [7:0]  RELOAD_LOW_RST   = 8'h00;
    localparam logic [23:0] RELOAD_RST       = {RELOAD_UPPER_RST, RELOAD_HIGH_RST,
                                                RELOAD_LOW_RST};

    // refresh is refused once the count is at or below this value
    localparam logic [23:0] REFRESH_BLOCK    = 24'h000002;
    // smallest reload software may program; the core does not enforce it
    localparam logic [23:0] RELOAD_MIN       = 24'h000004;
    localparam logic [23:0] COUNT_ZERO       = 24'h000000;
    localparam logic [23:0] COUNT_WRAP       = 24'hFFFFFF;

    // unlock sequence written to the unlock port
    localparam logic [7:0]  UNLOCK_FIRST     = 8'h55;
    localparam logic [7:0]  UNLOCK_SECOND    = 8'hAA;

    // oscillator timing: one count per oscillator period
    localparam int RC_TYP_HZ       = 10000;
    localparam int RC_PERIOD_NS    = 1000000000 / RC_TYP_HZ;
    localparam int SYS_PERIOD_NS   = 4;
    localparam int RC_PERIOD_CYC   = RC_PERIOD_NS / SYS_PERIOD_NS;
    // time-out in ms is reload / this divisor at the typical rate
    localparam int MS_DIVISOR      = RC_TYP_HZ / 1000;

    // synchroniser depth for the oscillator pin
    localparam int SYNC_STAGES     = 2;

    // register selects of the write / read port
    typedef enum logic [1:0] {
        WDG_SEL_UNLOCK,
        WDG_SEL_UPPER,
        WDG_SEL_HIGH,
        WDG_SEL_LOW
    } wdg_sel_t;

    typedef struct packed {
        logic       en;
        wdg_sel_t   sel;
        logic [7:0] data;
    } wdg_write_t;

    typedef struct packed {
        logic       irqReq;
        logic       systemResetReq;
        logic       timeoutPulse;
    } wdg_event_t;

endpackage

// ### logic/wdg_tick_sync.sv
// wdg_tick_sync: brings the free-running oscillator pin into clk_sys and
// marks each rising edge with a one-cycle tick.
// assumes the oscillator is far slower than clk_sys (many sys cycles per half period).
`timescale 1ns/100ps
module wdg_tick_sync #(
    parameter int STAGES = 2
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic oscIn,
    output logic      tick
);
    import wdg_pkg::*;

    // a single flop would let a metastable pin value through
    if (STAGES < 2) begin : g_bad_stages
        $error("wdg_tick_sync needs at least two stages");
    end

    logic [STAGES-1:0] syncChain;
    logic              oscLast;
    wire logic         oscSync = syncChain[STAGES-1];

    // only the last stage is looked at; earlier stages may be metastable
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            syncChain <= '0;
            oscLast   <= 1'b0;
        end else begin
            syncChain <= {syncChain[STAGES-2:0], oscIn};
            oscLast   <= oscSync;
        end
    end

    // one tick per oscillator period, never two
    assign tick = oscSync & ~oscLast;
endmodule

// ### logic/wdg_watchdog_core.sv
// wdg_watchdog_core: reloadable 24-bit down-counting watchdog with unlockable
// reload bytes, reset or interrupt response, and a sticky reset-cause flag.
// assumes the cpu drives a one-cycle pulse per watchdog instruction, the option
// bits are static flash straps, and por_rst is a power-on reset that outlives
// the system reset this block requests.
`timescale 1ns/100ps
module wdg_watchdog_core #(
    parameter int SYNC_DEPTH = wdg_pkg::SYNC_STAGES
) (
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    input  wire logic                     por_rst,
    input  wire logic                     rcOscIn,
    input  wire logic                     timeoutResetSelectOption,
    input  wire logic                     alwaysOnOption,
    input  wire logic                     runOrHaltMode,
    input  wire logic                     watchdogInstr,
    input  wire wdg_pkg::wdg_write_t      regWrite,
    input  wire wdg_pkg::wdg_sel_t        readSel,
    input  wire logic                     causeFlagClear,
    output logic [7:0]                    readData,
    output logic [23:0]                   countValue,
    output logic                          watchdogOn,
    output logic                          reloadUnlocked,
    output logic                          watchdogCauseFlag,
    output wdg_pkg::wdg_event_t           events
);
    import wdg_pkg::*;

    // the byte lanes below serve exactly three bytes
    if (COUNT_W != 3 * BYTE_W) begin : g_bad_width
        $error("reload must be exactly three bytes wide");
    end
    // one flop alone would let a metastable pin value reach the counter
    if (SYNC_DEPTH < 2) begin : g_bad_sync
        $error("oscillator pin needs at least two synchroniser stages");
    end

    typedef enum logic {
        WDG_OFF,
        WDG_ON
    } wdg_run_t;

    typedef enum logic [1:0] {
        WDG_LOCKED,
        WDG_HALF_UNLOCKED,
        WDG_UNLOCKED
    } wdg_lock_t;

    wdg_run_t    runState;
    wdg_run_t    next_runState;
    wdg_lock_t   lockState;
    wdg_lock_t   next_lockState;
    logic [7:0]  reloadByte [3];
    logic [23:0] count;
    logic [23:0] next_count;
    logic        irqLevel;
    logic        next_irqLevel;
    logic        resetReq;
    logic        timeoutEvt;
    logic        oscTick;

    // oscillator pin enters the system domain here
    wdg_tick_sync #(
        .STAGES (SYNC_DEPTH)
    ) wdg_tick_sync_i (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .oscIn   (rcOscIn),
        .tick    (oscTick)
    );

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire logic [23:0] reloadValue   = {reloadByte[2], reloadByte[1], reloadByte[0]};
    wire logic        isOn          = (runState == WDG_ON);
    wire logic        atTerminal    = (count == COUNT_ZERO);
    wire logic        refreshOpen   = (count > REFRESH_BLOCK);
    wire logic        doRefresh     = watchdogInstr & refreshOpen;
    wire logic        countStep     = isOn & oscTick;
    wire logic        resetResponse = timeoutResetSelectOption & runOrHaltMode;
    wire logic        timeoutHit    = countStep & atTerminal;
    // time-out response decode shared by the irq, the pulses and the cause flag
    wire logic        irqSet        = timeoutHit & ~resetResponse;
    wire logic        irqClear      = irqLevel & (countStep | doRefresh);
    wire logic        causeSet      = timeoutHit & resetResponse;

    wire logic        unlockWrite   = regWrite.en & (regWrite.sel == WDG_SEL_UNLOCK);
    wire logic        reloadWrite   = regWrite.en & (regWrite.sel != WDG_SEL_UNLOCK)
                                      & (lockState == WDG_UNLOCKED);
    wire logic        lowWrite      = reloadWrite & (regWrite.sel == WDG_SEL_LOW);

    // ------------------------------------------------------------------
    // on / off: there is no way back to off except a reset
    // ------------------------------------------------------------------
    always_comb begin
        next_runState = runState;
        case (runState)
            WDG_OFF: begin
                // the strap is sampled by the clock after reset release
                if (watchdogInstr || alwaysOnOption) begin
                    next_runState = WDG_ON;
                end
            end
            WDG_ON: begin
                next_runState = WDG_ON;
            end
            default: begin
                next_runState = WDG_OFF;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // unlock sequence; the writes themselves alter no stored bits
    // ------------------------------------------------------------------
    always_comb begin
        next_lockState = lockState;
        case (lockState)
            WDG_LOCKED: begin
                if (unlockWrite && regWrite.data == UNLOCK_FIRST) begin
                    next_lockState = WDG_HALF_UNLOCKED;
                end
            end
            WDG_HALF_UNLOCKED: begin
                if (unlockWrite) begin
                    next_lockState = (regWrite.data == UNLOCK_SECOND) ? WDG_UNLOCKED
                                                                     : WDG_LOCKED;
                end else if (regWrite.en) begin
                    next_lockState = WDG_LOCKED;
                end
            end
            WDG_UNLOCKED: begin
                // writing the low byte completes a reload and relocks
                if (lowWrite || unlockWrite) begin
                    next_lockState = WDG_LOCKED;
                end
            end
            default: begin
                next_lockState = WDG_LOCKED;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // counter: refresh wins over a step in the same cycle
    // ------------------------------------------------------------------
    always_comb begin
        next_count = count;
        if (!isOn) begin
            // whatever switches it on also loads the reload value, so a strap
            // start after a watchdog reset keeps the programmed period
            if (watchdogInstr || alwaysOnOption) begin
                next_count = reloadValue;
            end
        end else if (doRefresh) begin
            next_count = reloadValue;
        end else if (countStep) begin
            if (atTerminal) begin
                // a reset response restarts from reload; the interrupt one wraps
                next_count = resetResponse ? reloadValue : COUNT_WRAP;
            end else begin
                next_count = count - 24'h000001;
            end
        end
    end

    // interrupt holds from the wrap step off terminal count until the next step or a refresh
    always_comb begin
        next_irqLevel = irqLevel;
        if (irqSet) begin
            next_irqLevel = 1'b1;
        end else if (irqClear) begin
            next_irqLevel = 1'b0;
        end
    end

    // run state has no way back to off short of a reset
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            runState <= WDG_OFF;
        end else begin
            runState <= next_runState;
        end
    end

    // lock state is volatile: any system reset relocks the reload bytes
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lockState <= WDG_LOCKED;
        end else begin
            lockState <= next_lockState;
        end
    end

    // a system reset parks the count at the reset reload; the strap path
    // then loads the programmed reload on the first clock after release
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            count <= RELOAD_RST;
        end else begin
            count <= next_count;
        end
    end

    // the irq level is a flop so the interrupt controller sees no glitch
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irqLevel <= 1'b0;
        end else begin
            irqLevel <= next_irqLevel;
        end
    end

    // time-out pulses; the reset request is held one cycle for the reset logic
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            resetReq <= 1'b0;
        end else begin
            resetReq <= causeSet;
        end
    end

    // every terminal-count step is reported once, whatever the response
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            timeoutEvt <= 1'b0;
        end else begin
            timeoutEvt <= timeoutHit;
        end
    end

    // ------------------------------------------------------------------
    // reload bytes keep their value across the system reset they may cause;
    // lane 0 is the low byte, lane 2 the upper byte
    // ------------------------------------------------------------------
    genvar lane;
    generate
        for (lane = 0; lane < 3; lane = lane + 1) begin : g_reload_lane
            // select codes run upper, high, low, so lane n answers code 3 - n
            wire logic laneWrite = reloadWrite & (regWrite.sel == wdg_sel_t'(2'(3 - lane)));

            always_ff @(posedge clk_sys or posedge por_rst) begin
                if (por_rst) begin
                    reloadByte[lane] <= RELOAD_RST[lane*BYTE_W +: BYTE_W];
                end else if (laneWrite) begin
                    reloadByte[lane] <= regWrite.data;
                end
            end
        end
    endgenerate

    // cause flag lives on the power-on reset; a new time-out beats a clear
    always_ff @(posedge clk_sys or posedge por_rst) begin
        if (por_rst) begin
            watchdogCauseFlag <= 1'b0;
        end else if (causeSet) begin
            watchdogCauseFlag <= 1'b1;
        end else if (causeFlagClear) begin
            watchdogCauseFlag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // readback: reload addresses return the live count, one clock late;
    // the count moves far slower than that, so nothing is lost
    // ------------------------------------------------------------------
    wire logic [7:0] readMux = (readSel == WDG_SEL_UPPER) ? count[23:16] :
                               (readSel == WDG_SEL_HIGH)  ? count[15:8]  :
                               (readSel == WDG_SEL_LOW)   ? count[7:0]   :
                                                            8'h00;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            readData <= 8'h00;
        end else begin
            readData <= readMux;
        end
    end

    assign countValue            = count;
    assign watchdogOn            = isOn;
    assign reloadUnlocked        = (lockState == WDG_UNLOCKED);
    assign events = '{irqReq: irqLevel, systemResetReq: resetReq, timeoutPulse: timeoutEvt};
endmodule

// ### test/wdg_watchdog_checker.sv
// wdg_watchdog_checker: timing relations at the watchdog core's ports.
// assumes it is bound to wdg_watchdog_core and sees only its ports.
`timescale 1ns/100ps
module wdg_watchdog_checker
    import wdg_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        timeoutResetSelectOption,
    input wire logic        alwaysOnOption,
    input wire logic        runOrHaltMode,
    input wire logic        watchdogInstr,
    input wire wdg_write_t  regWrite,
    input wire wdg_sel_t    readSel,
    input wire logic [7:0]  readData,
    input wire logic [23:0] countValue,
    input wire logic        watchdogOn,
    input wire logic        reloadUnlocked,
    input wire logic        watchdogCauseFlag,
    input wire wdg_event_t  events
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire resetResp = timeoutResetSelectOption && runOrHaltMode;

    a_reset_on_timeout: assert property (events.timeoutPulse && resetResp |-> events.systemResetReq)
        else $error("time-out without system reset request");
    a_reset_only_sel: assert property (events.systemResetReq |-> resetResp)
        else $error("system reset request in interrupt response");
    a_cause_flag_set: assert property (events.systemResetReq |-> watchdogCauseFlag)
        else $error("cause flag not set with watchdog reset");
    a_irq_wraps: assert property ($rose(events.irqReq) |-> countValue == 24'hFFFFFF && !resetResp)
        else $error("interrupt raised without wrap or in reset response");
    a_irq_ends_roll: assert property ($fell(events.irqReq) |-> $past(countValue) == 24'hFFFFFF)
        else $error("interrupt dropped before rollover");
    a_count_step: assert property (watchdogOn && !watchdogInstr && countValue != 24'h0
        |=> countValue == $past(countValue) || countValue == $past(countValue) - 24'h1)
        else $error("counter moved by more than one step");
    a_off_still: assert property (!watchdogOn && !watchdogInstr && !alwaysOnOption
        |=> $stable(countValue))
        else $error("counter moved while off");
    a_stays_on: assert property (watchdogOn |=> watchdogOn)
        else $error("watchdog turned off");
    a_instr_enables: assert property (watchdogInstr || alwaysOnOption |=> watchdogOn)
        else $error("watchdog not on after enable");
    a_refresh_blocked: assert property (watchdogInstr && countValue <= 24'h2 && countValue != 24'h0
        |=> countValue <= 24'h2)
        else $error("refresh reloaded a nearly expired count");
    // en=1, sel=unlock, data=AA packs to 4AA
    a_unlock_order: assert property ($rose(reloadUnlocked) |-> $past(regWrite) == 11'h4AA)
        else $error("unlock without second unlock byte");
    a_read_count: assert property (readSel == WDG_SEL_LOW |=> readData == $past(countValue[7:0]))
        else $error("read does not return count byte");
endmodule

// ### test/wdg_rc_osc_model.sv
// wdg_rc_osc_model: stand-in for the watchdog's dedicated rc oscillator.
// assumes run is driven on clk_sys; the pin stands low while run is low.
`timescale 1ns/100ps
module wdg_rc_osc_model #(
    parameter int HALF = 4
) (
    input  wire logic clk_sys,
    input  wire logic run,
    output logic      rcOscIn
);
    int phase;
    // bursts always start and end low, so each burst gives whole ticks
    always_ff @(posedge clk_sys) begin
        if (!run) begin
            phase   <= 0;
            rcOscIn <= 1'b0;
        end else if (phase == HALF - 1) begin
            phase   <= 0;
            rcOscIn <= ~rcOscIn;
        end else begin
            phase <= phase + 1;
        end
    end
endmodule

// ### test/tb_wdg_watchdog_core.sv
// tb_wdg_watchdog_core: directed scenarios for the watchdog core.
// assumes wdg_pkg, the core, the oscillator model and the checker are compiled first.
`timescale 1ns/100ps
module tb_wdg_watchdog_core;
    import wdg_pkg::*;
    localparam int HALF = 4;
    logic clk_sys = 1'b0, sys_rst = 1'b1, por_rst = 1'b1, oscRun = 1'b0, rcOscIn;
    logic timeoutResetSelectOption = 1'b1, alwaysOnOption = 1'b0, runOrHaltMode = 1'b1;
    logic watchdogInstr = 1'b0, causeFlagClear = 1'b0;
    wdg_write_t regWrite = '0;
    wdg_sel_t   readSel = WDG_SEL_UNLOCK;
    logic [7:0] readData;
    logic [23:0] countValue;
    logic watchdogOn, reloadUnlocked, watchdogCauseFlag;
    wdg_event_t events;
    int errTotal = 0, nChecks = 0, rstPulses = 0, toPulses = 0, p, q;

    always #2 clk_sys = ~clk_sys;
    always @(negedge clk_sys) if (events.systemResetReq === 1'b1) rstPulses++;
    always @(negedge clk_sys) if (events.timeoutPulse === 1'b1) toPulses++;

    wdg_rc_osc_model #(.HALF(HALF)) wdg_rc_osc_model_i (.clk_sys(clk_sys), .run(oscRun),
        .rcOscIn(rcOscIn));
    wdg_watchdog_core wdg_watchdog_core_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .por_rst(por_rst), .rcOscIn(rcOscIn), .timeoutResetSelectOption(timeoutResetSelectOption),
        .alwaysOnOption(alwaysOnOption), .runOrHaltMode(runOrHaltMode),
        .watchdogInstr(watchdogInstr), .regWrite(regWrite), .readSel(readSel),
        .causeFlagClear(causeFlagClear), .readData(readData), .countValue(countValue),
        .watchdogOn(watchdogOn), .reloadUnlocked(reloadUnlocked),
        .watchdogCauseFlag(watchdogCauseFlag), .events(events));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        nChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one oscillator period per step, then time for the synchroniser
    task automatic steps(input int n);
        @(posedge clk_sys) oscRun <= 1'b1;
        cyc(n * 2 * HALF);
        oscRun <= 1'b0;
        cyc(6);
    endtask
    task automatic instr();
        @(posedge clk_sys) watchdogInstr <= 1'b1;
        @(posedge clk_sys) watchdogInstr <= 1'b0;
        cyc(1);
    endtask
    task automatic wr(input wdg_sel_t s, input logic [7:0] d);
        @(posedge clk_sys) regWrite <= '{en: 1'b1, sel: s, data: d};
        @(posedge clk_sys) regWrite.en <= 1'b0;
        cyc(1);
    endtask
    // readData is registered, so it is looked at two edges after the select
    task automatic rd(input wdg_sel_t s, input logic [7:0] e);
        @(posedge clk_sys) readSel <= s;
        cyc(2);
        chk("read", {16'h0, e}, {16'h0, readData});
    endtask

    task automatic t_reset_state();
        chk("on", 24'h0, {23'h0, watchdogOn});
        chk("count", RELOAD_RST, countValue);
        chk("unlocked", 24'h0, {23'h0, reloadUnlocked});
        chk("cause", 24'h0, {23'h0, watchdogCauseFlag});
    endtask
    task automatic t_enable_refresh();
        instr();
        chk("on", 24'h1, {23'h0, watchdogOn});
        chk("count", 24'h000400, countValue);
        steps(3);
        chk("count", 24'h0003FD, countValue);
        rd(WDG_SEL_HIGH, 8'h03);
        rd(WDG_SEL_UNLOCK, 8'h00);
        instr();
        chk("count", 24'h000400, countValue);
    endtask
    task automatic t_unlock_reload();
        wr(WDG_SEL_UNLOCK, 8'h55);
        wr(WDG_SEL_UNLOCK, 8'hAA);
        chk("unlocked", 24'h1, {23'h0, reloadUnlocked});
        wr(WDG_SEL_UPPER, 8'h00);
        wr(WDG_SEL_HIGH, 8'h00);
        wr(WDG_SEL_LOW, 8'h06);
        chk("unlocked", 24'h0, {23'h0, reloadUnlocked});
        wr(WDG_SEL_HIGH, 8'h12);
        instr();
        chk("count", 24'h000006, countValue);
        rd(WDG_SEL_LOW, 8'h06);
    endtask
    task automatic t_timeout_reset();
        steps(4);
        instr();
        chk("count", 24'h000002, countValue);
        p = rstPulses;
        q = toPulses;
        steps(3);
        chk("count", 24'h000006, countValue);
        chk("resets", 24'h1, 24'(rstPulses - p));
        chk("timeouts", 24'h1, 24'(toPulses - q));
        chk("cause", 24'h1, {23'h0, watchdogCauseFlag});
        @(posedge clk_sys) causeFlagClear <= 1'b1;
        @(posedge clk_sys) causeFlagClear <= 1'b0;
        cyc(1);
        chk("cause", 24'h0, {23'h0, watchdogCauseFlag});
    endtask
    task automatic t_timeout_irq();
        @(posedge clk_sys) timeoutResetSelectOption <= 1'b0;
        p = rstPulses;
        q = toPulses;
        steps(7);
        chk("irq", 24'h1, {23'h0, events.irqReq});
        chk("count", 24'hFFFFFF, countValue);
        cyc(40);
        chk("irq", 24'h1, {23'h0, events.irqReq});
        chk("resets", 24'h0, 24'(rstPulses - p));
        chk("timeouts", 24'h1, 24'(toPulses - q));
        steps(1);
        chk("irq", 24'h0, {23'h0, events.irqReq});
        chk("count", 24'hFFFFFE, countValue);
    endtask
    // strap start after a system reset, outside normal/halt operation
    task automatic t_always_on();
        @(posedge clk_sys) alwaysOnOption <= 1'b1;
        timeoutResetSelectOption <= 1'b1;
        runOrHaltMode <= 1'b0;
        sys_rst <= 1'b1;
        cyc(2);
        sys_rst <= 1'b0;
        cyc(2);
        chk("on", 24'h1, {23'h0, watchdogOn});
        chk("count", 24'h000006, countValue);
        p = rstPulses;
        steps(7);
        chk("irq", 24'h1, {23'h0, events.irqReq});
        chk("count", 24'hFFFFFF, countValue);
        chk("resets", 24'h0, 24'(rstPulses - p));
    endtask

    task automatic endSim();
        $display("checks %0d errors %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        cyc(4);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        cyc(2);
        t_reset_state();
        t_enable_refresh();
        t_unlock_reload();
        t_timeout_reset();
        t_timeout_irq();
        t_always_on();
        endSim();
    end
    // whole run is a few hundred cycles; this bound only catches a hang
    initial begin
        cyc(20000);
        errTotal++;
        endSim();
    end
endmodule

bind wdg_watchdog_core wdg_watchdog_checker wdg_watchdog_checker_i (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .timeoutResetSelectOption(timeoutResetSelectOption),
    .alwaysOnOption(alwaysOnOption), .runOrHaltMode(runOrHaltMode),
    .watchdogInstr(watchdogInstr), .regWrite(regWrite), .readSel(readSel),
    .readData(readData), .countValue(countValue), .watchdogOn(watchdogOn),
    .reloadUnlocked(reloadUnlocked), .watchdogCauseFlag(watchdogCauseFlag), .events(events));
